// file: verilog/umc_map.svh
// register map, field positions and reset values of the mode control block
// assumes: included by the package user files only by bare name
`ifndef UMC_MAP_SVH
`define UMC_MAP_SVH
// ==========================================================
// offsets
`define UMC_OFS_CTL3      8'h14
`define UMC_OFS_GPR       8'h18
`define UMC_OFS_IRQ_STAT  8'h20
`define UMC_OFS_IRQ_CLR   8'h24
`define UMC_OFS_IRQ_EN    8'h28
// ==========================================================
// masks and reset values
`define UMC_CTL3_MASK     32'h0000_07ff
`define UMC_GPR_MASK      32'h0000_ffff
`define UMC_IRQ_MASK      32'h0000_0007
`define UMC_RST_WORD      32'h0000_0000
// ==========================================================
// control register three fields
`define UMC_B_CLEAR_TO_SEND_IRQ_ENABLE       10
`define UMC_B_CLEAR_TO_SEND_FLOW_ENABLE        9
`define UMC_B_REQUEST_TO_SEND_FLOW_ENABLE        8
`define UMC_B_TX_DMA_ENABLE        7
`define UMC_B_RX_DMA_ENABLE        6
`define UMC_B_SMART_CARD_ENABLE        5
`define UMC_B_NACK        4
`define UMC_B_HALF_DUPLEX_SELECT       3
`define UMC_B_INFRARED_LOW_POWER        2
`define UMC_B_INFRARED_ENABLE        1
`define UMC_B_EIE         0
// ==========================================================
// guard time and prescaler fields
`define UMC_GT_HI         15
`define UMC_GT_LO         8
`define UMC_PSC_HI        7
`define UMC_PSC_LO        0
`define UMC_SC_PSC_HI     4
// ==========================================================
// interrupt status bits
`define UMC_I_CTS         0
`define UMC_I_ERR         1
`define UMC_I_TC          2
// ==========================================================
// bus answers
`define UMC_RESP_OKAY     2'h0
`define UMC_RESP_SLVERR   2'h2
`endif

// file: verilog/umc_pkg.sv
// types shared by the mode control block
// assumes: nothing beyond a SystemVerilog compiler
package umc_pkg;
   typedef logic [31:0] umc_word_t;
   typedef logic [7:0]  umc_addr_t;
   typedef logic [7:0]  umc_byte_t;
   typedef logic [3:0]  umc_strb_t;
   typedef logic [1:0]  umc_resp_t;
   typedef enum logic {umc_gt_idle, umc_gt_run} umc_gt_e;
endpackage

// file: verilog/umc_mode_ctrl.sv
// mode and option control of a serial transceiver, axi4-lite slave
// assumes: core status inputs are pulses/levels synchronous to aclk,
// baud_tick is a one-cycle enable at the baud rate
//
// The AXI4-Lite slave port is this design's own decision.
`include "umc_map.svh"

// Behaviour
// R1: cts change raises interrupt when enabled
// R2: cts enable gates transmission on cts
// R3: rts enable drives rts from receiver
// R4: tx dma enable requests transmit data
// R5: rx dma enable requests receive hand-off
// R6: smart card enable selects smart card mode
// R7: nack sent on parity error in card
// R8: half-duplex select gives single-line operation
// R9: low-power bit selects infrared low-power pulses
// R10: infrared enable routes data through encoder
// R11: error interrupt needs error enable and dma
// R12: guard time field counts baud periods
// R13: card mode delays tx complete by guard
// R14: low-power infrared divides by prescaler, zero holds
// R15: software keeps prescaler one in normal infrared
// R16: card clock divides by twice low prescaler
// R17: fields reset cleared, reserved bits read zero
module umc_mode_ctrl
   import umc_pkg::*;
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire umc_pkg::umc_addr_t awaddr,
   input  wire logic             awvalid,
   output logic                  awready,
   input  wire umc_pkg::umc_word_t wdata,
   input  wire umc_pkg::umc_strb_t wstrb,
   input  wire logic             wvalid,
   output logic                  wready,
   output umc_pkg::umc_resp_t    bresp,
   output logic                  bvalid,
   input  wire logic             bready,
   input  wire umc_pkg::umc_addr_t araddr,
   input  wire logic             arvalid,
   output logic                  arready,
   output umc_pkg::umc_word_t    rdata,
   output umc_pkg::umc_resp_t    rresp,
   output logic                  rvalid,
   input  wire logic             rready,
   input  wire logic             cts_n,
   input  wire logic             cts_change,
   input  wire logic             rx_can_accept,
   input  wire logic             tx_empty,
   input  wire logic             rx_full,
   input  wire logic             tx_char_done,
   input  wire logic             rx_parity_err,
   input  wire logic             framing_error_flag,
   input  wire logic             overrun_error_flag,
   input  wire logic             noise_error_flag,
   input  wire logic             baud_tick,
   output logic                  tx_allow,
   output logic                  rts_n,
   output logic                  tx_dma_req,
   output logic                  rx_dma_req,
   output logic                  smart_card_mode,
   output logic                  half_duplex_mode,
   output logic                  infrared_mode,
   output logic                  infrared_lp_mode,
   output logic                  nack_pulse,
   output logic                  tx_complete,
   output logic                  ir_lp_tick,
   output logic                  card_clk,
   output logic                  irq
);
   import umc_pkg::*;

   // =======================================================
   // helpers
   function automatic umc_word_t apply_strb(input umc_word_t old,
      input umc_word_t nw, input umc_strb_t st);
      umc_word_t r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (st[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // divider wraps when the count reaches the limit minus one
   function automatic logic div_hit(input umc_byte_t cnt,
      input umc_byte_t lim);
      return cnt >= (lim - 8'h01);
   endfunction

   // =======================================================
   // registers
   umc_word_t ctl3_r, gpr_r, stat_r, en_r;
   umc_word_t stat_nxt;
   umc_addr_t aw_q_r;
   umc_word_t w_q_r;
   umc_strb_t s_q_r;
   logic      aw_full_r, w_full_r;
   logic      awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   umc_resp_t bresp_r, rresp_r;
   umc_word_t rdata_r;
   logic      irq_r;

   // =======================================================
   // field decode
   wire f_clear_to_send_irq_enable = ctl3_r[`UMC_B_CLEAR_TO_SEND_IRQ_ENABLE];
   wire f_clear_to_send_flow_enable  = ctl3_r[`UMC_B_CLEAR_TO_SEND_FLOW_ENABLE];
   wire f_request_to_send_flow_enable  = ctl3_r[`UMC_B_REQUEST_TO_SEND_FLOW_ENABLE];
   wire f_tx_dma_enable  = ctl3_r[`UMC_B_TX_DMA_ENABLE];
   wire f_rx_dma_enable  = ctl3_r[`UMC_B_RX_DMA_ENABLE];
   wire f_smart_card_enable  = ctl3_r[`UMC_B_SMART_CARD_ENABLE];
   wire f_nack  = ctl3_r[`UMC_B_NACK];
   wire f_half_duplex_select = ctl3_r[`UMC_B_HALF_DUPLEX_SELECT];
   wire f_infrared_low_power  = ctl3_r[`UMC_B_INFRARED_LOW_POWER];
   wire f_infrared_enable  = ctl3_r[`UMC_B_INFRARED_ENABLE];
   wire f_eie   = ctl3_r[`UMC_B_EIE];
   wire umc_byte_t f_gt  = gpr_r[`UMC_GT_HI:`UMC_GT_LO];
   wire umc_byte_t f_psc = gpr_r[`UMC_PSC_HI:`UMC_PSC_LO];
   wire umc_byte_t f_scp =
      {3'h0, f_psc[`UMC_SC_PSC_HI:`UMC_PSC_LO]};

   // =======================================================
   // axi write path
   wire aw_hs = awvalid & awready_r;
   wire w_hs  = wvalid & wready_r;
   wire do_wr = aw_full_r & w_full_r & ~bvalid_r;
   wire aw_full_nxt = (aw_full_r | aw_hs) & ~do_wr;
   wire w_full_nxt  = (w_full_r | w_hs) & ~do_wr;
   wire bvalid_nxt  = do_wr | (bvalid_r & ~bready);
   wire wsel_ctl3 = aw_q_r == `UMC_OFS_CTL3;
   wire wsel_gpr  = aw_q_r == `UMC_OFS_GPR;
   wire wsel_clr  = aw_q_r == `UMC_OFS_IRQ_CLR;
   wire wsel_en   = aw_q_r == `UMC_OFS_IRQ_EN;
   wire wsel_stat = aw_q_r == `UMC_OFS_IRQ_STAT;
   wire wr_hit = wsel_ctl3 | wsel_gpr | wsel_clr | wsel_en | wsel_stat;
   wire umc_word_t clr_mask =
      (do_wr & wsel_clr) ? apply_strb(`UMC_RST_WORD, w_q_r, s_q_r)
                         : `UMC_RST_WORD;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `UMC_RESP_OKAY;
         aw_q_r    <= 8'h00;
         w_q_r     <= `UMC_RST_WORD;
         s_q_r     <= 4'h0;
      end
      else
      begin
         aw_full_r <= aw_full_nxt;
         w_full_r  <= w_full_nxt;
         awready_r <= ~aw_full_nxt & ~bvalid_nxt;
         wready_r  <= ~w_full_nxt & ~bvalid_nxt;
         bvalid_r  <= bvalid_nxt;
         if (aw_hs)
            aw_q_r <= awaddr;
         if (w_hs)
         begin
            w_q_r <= wdata;
            s_q_r <= wstrb;
         end
         if (do_wr)
            bresp_r <= wr_hit ? `UMC_RESP_OKAY : `UMC_RESP_SLVERR;
      end
   end

   // status is read-only: a write to it is accepted and dropped
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctl3_r <= `UMC_RST_WORD; // [R17]
         gpr_r  <= `UMC_RST_WORD; // [R17]
         en_r   <= `UMC_RST_WORD;
      end
      else if (do_wr)
      begin
         if (wsel_ctl3)
            ctl3_r <= apply_strb(ctl3_r, w_q_r, s_q_r)
                      & `UMC_CTL3_MASK; // [R17]
         if (wsel_gpr)
            gpr_r <= apply_strb(gpr_r, w_q_r, s_q_r)
                     & `UMC_GPR_MASK; // [R12] [R17]
         if (wsel_en)
            en_r <= apply_strb(en_r, w_q_r, s_q_r) & `UMC_IRQ_MASK;
      end
   end

   // =======================================================
   // axi read path
   wire ar_hs = arvalid & arready_r;
   wire rvalid_nxt = ar_hs | (rvalid_r & ~rready);
   wire rsel_ctl3 = araddr == `UMC_OFS_CTL3;
   wire rsel_gpr  = araddr == `UMC_OFS_GPR;
   wire rsel_stat = araddr == `UMC_OFS_IRQ_STAT;
   wire rsel_en   = araddr == `UMC_OFS_IRQ_EN;
   wire rsel_clr  = araddr == `UMC_OFS_IRQ_CLR;
   wire rd_hit = rsel_ctl3 | rsel_gpr | rsel_stat | rsel_en | rsel_clr;
   // the clear register is write-only and reads zero
   wire umc_word_t rd_word =
      rsel_ctl3 ? ctl3_r :
      rsel_gpr  ? gpr_r  :
      rsel_stat ? stat_r :
      rsel_en   ? en_r   : `UMC_RST_WORD;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= `UMC_RST_WORD;
         rresp_r   <= `UMC_RESP_OKAY;
      end
      else
      begin
         arready_r <= ~rvalid_nxt;
         rvalid_r  <= rvalid_nxt;
         if (ar_hs)
         begin
            rdata_r <= rd_word;
            rresp_r <= rd_hit ? `UMC_RESP_OKAY : `UMC_RESP_SLVERR;
         end
      end
   end

   // =======================================================
   // flow control, dma and mode outputs
   logic tx_allow_r, rts_n_r, txdma_r, rxdma_r;
   logic sc_r, hd_r, ir_r, infrared_low_power_r, nack_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_allow_r <= 1'b1;
         rts_n_r    <= 1'b0;
         txdma_r    <= 1'b0;
         rxdma_r    <= 1'b0;
         sc_r       <= 1'b0;
         hd_r       <= 1'b0;
         ir_r       <= 1'b0;
         infrared_low_power_r     <= 1'b0;
         nack_r     <= 1'b0;
      end
      else
      begin
         tx_allow_r <= ~f_clear_to_send_flow_enable | ~cts_n; // [R2]
         rts_n_r    <= f_request_to_send_flow_enable & ~rx_can_accept; // [R3]
         txdma_r    <= f_tx_dma_enable & tx_empty; // [R4]
         rxdma_r    <= f_rx_dma_enable & rx_full; // [R5]
         sc_r       <= f_smart_card_enable; // [R6]
         hd_r       <= f_half_duplex_select; // [R8]
         ir_r       <= f_infrared_enable; // [R10]
         infrared_low_power_r     <= f_infrared_enable & f_infrared_low_power; // [R9]
         nack_r     <= f_smart_card_enable & f_nack & rx_parity_err; // [R7]
      end
   end

   // =======================================================
   // guard time before transmit complete
   umc_gt_e   gt_st_r;
   umc_byte_t gt_cnt_r;
   logic      tc_r;
   wire gt_load = (gt_st_r == umc_gt_idle) & tx_char_done
                  & f_smart_card_enable & (f_gt != 8'h00);
   wire gt_done = (gt_st_r == umc_gt_run) & baud_tick
                  & (gt_cnt_r == 8'h01);
   // outside card mode the flag follows the character directly
   wire tc_set = gt_done | (tx_char_done & ~f_smart_card_enable)
                 | (tx_char_done & f_smart_card_enable & (f_gt == 8'h00)
                    & (gt_st_r == umc_gt_idle));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gt_st_r  <= umc_gt_idle;
         gt_cnt_r <= 8'h00;
         tc_r     <= 1'b0;
      end
      else
      begin
         tc_r <= tc_set; // [R13]
         unique case (gt_st_r)
            umc_gt_idle:
               if (gt_load)
               begin
                  gt_st_r  <= umc_gt_run;
                  gt_cnt_r <= f_gt; // [R12]
               end
            umc_gt_run:
               if (!f_smart_card_enable || gt_done)
                  gt_st_r <= umc_gt_idle; // [R13]
               else if (baud_tick)
                  gt_cnt_r <= gt_cnt_r - 8'h01;
         endcase
      end
   end

   // =======================================================
   // prescalers: low-power infrared tick and card clock
   umc_byte_t ir_cnt_r, sc_cnt_r;
   logic      ir_tick_r, card_clk_r;
   wire ir_run = f_infrared_enable & f_infrared_low_power & (f_psc != 8'h00);
   wire sc_run = f_smart_card_enable & (f_scp != 8'h00);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ir_cnt_r   <= 8'h00;
         ir_tick_r  <= 1'b0;
         sc_cnt_r   <= 8'h00;
         card_clk_r <= 1'b0;
      end
      else
      begin
         ir_tick_r <= ir_run & div_hit(ir_cnt_r, f_psc); // [R14]
         if (!ir_run)
            ir_cnt_r <= 8'h00; // [R14]
         else if (div_hit(ir_cnt_r, f_psc))
            ir_cnt_r <= 8'h00;
         else
            ir_cnt_r <= ir_cnt_r + 8'h01;
         // half period is the low five prescaler bits, so full period is twice that value
         if (!f_smart_card_enable)
         begin
            sc_cnt_r   <= 8'h00;
            card_clk_r <= 1'b0;
         end
         else if (sc_run && div_hit(sc_cnt_r, f_scp))
         begin
            sc_cnt_r   <= 8'h00;
            card_clk_r <= ~card_clk_r; // [R16]
         end
         else if (sc_run)
            sc_cnt_r <= sc_cnt_r + 8'h01;
      end
   end

   // =======================================================
   // interrupt status, enable and output
   wire err_ev = framing_error_flag | overrun_error_flag
                 | noise_error_flag;
   wire umc_word_t ev_set = {29'h0, tc_r, err_ev, cts_change};
   wire umc_word_t gate = {29'h0, 1'b1, f_eie & f_rx_dma_enable, f_clear_to_send_irq_enable};
   // set wins over a clear in the same cycle
   assign stat_nxt = (stat_r & ~clr_mask) | ev_set;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         stat_r <= `UMC_RST_WORD;
         irq_r  <= 1'b0;
      end
      else
      begin
         stat_r <= stat_nxt & `UMC_IRQ_MASK;
         irq_r  <= |(stat_r & en_r & gate); // [R1] [R11]
      end
   end

   // =======================================================
   // outputs
   assign awready          = awready_r;
   assign wready           = wready_r;
   assign bvalid           = bvalid_r;
   assign bresp            = bresp_r;
   assign arready          = arready_r;
   assign rvalid           = rvalid_r;
   assign rdata            = rdata_r;
   assign rresp            = rresp_r;
   assign tx_allow         = tx_allow_r;
   assign rts_n            = rts_n_r;
   assign tx_dma_req       = txdma_r;
   assign rx_dma_req       = rxdma_r;
   assign smart_card_mode  = sc_r;
   assign half_duplex_mode = hd_r;
   assign infrared_mode    = ir_r;
   assign infrared_lp_mode = infrared_low_power_r;
   assign nack_pulse       = nack_r;
   assign tx_complete      = tc_r;
   assign ir_lp_tick       = ir_tick_r;
   assign card_clk         = card_clk_r;
   assign irq              = irq_r;

   // =======================================================
   // assertions
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   cts_irq_a: assert property ( // [R1]
      cts_change && f_clear_to_send_irq_enable && en_r[`UMC_I_CTS] && $stable(ctl3_r)
      |=> ##1 irq_r) else $error("cts change gave no interrupt");
   cts_flow_a: assert property ( // [R2]
      f_clear_to_send_flow_enable && cts_n |=> !tx_allow_r)
      else $error("transmit allowed while cts high");
   rts_flow_a: assert property ( // [R3]
      1'b1 |=> rts_n_r == $past(f_request_to_send_flow_enable && !rx_can_accept))
      else $error("rts does not follow receiver");
   tx_dma_a: assert property ( // [R4]
      1'b1 |=> txdma_r == $past(f_tx_dma_enable && tx_empty))
      else $error("tx dma request wrong");
   rx_dma_a: assert property ( // [R5]
      rxdma_r |-> $past(f_rx_dma_enable && rx_full))
      else $error("rx dma request without cause");
   nack_send_a: assert property ( // [R7]
      nack_r |-> $past(f_smart_card_enable && f_nack && rx_parity_err))
      else $error("nack without parity error in card mode");
   ir_lp_a: assert property ( // [R14]
      ir_tick_r |-> $past(ir_run)) else $error("ir tick while held");
   err_irq_a: assert property ( // [R11]
      irq_r && !$past(stat_r[`UMC_I_CTS]) && !$past(stat_r[`UMC_I_TC])
      |-> $past(f_eie && f_rx_dma_enable))
      else $error("error interrupt without dma enable");
   guard_hold_a: assert property ( // [R13]
      gt_load |=> !tc_r ##0 gt_cnt_r == $past(f_gt)) // [R12]
      else $error("tx complete not held for guard time");
   card_hold_a: assert property ( // [R16]
      !sc_run |=> $stable(card_clk_r) || !card_clk_r)
      else $error("card clock moved while held");
   reserved_a: assert property ( // [R17]
      (ctl3_r & ~`UMC_CTL3_MASK) == 32'h0 &&
      (gpr_r & ~`UMC_GPR_MASK) == 32'h0)
      else $error("reserved bits not zero");

   guard_c: cover property (gt_done ##1 tc_r);
   card_c:  cover property (sc_run ##1 $changed(card_clk_r));
   irq_c:   cover property (!irq_r ##1 irq_r);
   wr_c:    cover property (do_wr && wsel_ctl3 ##[1:4] bvalid_r);
endmodule // umc_mode_ctrl

// file: testbench/umc_peer_model.sv
// peer model: core-side status lines seen by the mode control block
// assumes: one clock, commanded by the bench through its tasks
module umc_peer_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   output logic      cts_n,
   output logic      cts_change,
   output logic      rx_can_accept,
   output logic      tx_empty,
   output logic      rx_full,
   output logic      tx_char_done,
   output logic      rx_parity_err,
   output logic      framing_error_flag,
   output logic      overrun_error_flag,
   output logic      noise_error_flag,
   output logic      baud_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // events last one cycle; baud ticks run free, every fourth cycle
   logic [5:0] ev_r;
   logic [1:0] bcnt_r;
   assign {noise_error_flag, overrun_error_flag, framing_error_flag,
           rx_parity_err, tx_char_done, cts_change} = ev_r;
   assign baud_tick = &bcnt_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         bcnt_r <= 2'h0;
      else
         bcnt_r <= bcnt_r + 2'h1;
   end
   initial
   begin
      ev_r = 6'h0;
      {cts_n, rx_can_accept, tx_empty, rx_full} = 4'hb;
   end
   // ==========
   // levels in order: cts_n, rx_can_accept, tx_empty, rx_full
   task automatic set_lv(input logic [3:0] v);
      @(posedge aclk);
      {cts_n, rx_can_accept, tx_empty, rx_full} <= v;
   endtask
   task automatic pulse(input int k);
      @(posedge aclk);
      ev_r[k] <= 1'b1;
      @(posedge aclk);
      ev_r[k] <= 1'b0;
   endtask
endmodule // umc_peer_model

// file: testbench/testbench.sv
// self-checking bench of the mode control block over axi4-lite
// assumes: umc_pkg, umc_map.svh and the peer model compiled first
`include "umc_map.svh"
module testbench
   import umc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      umc_word_t a;
      umc_word_t b;
      umc_word_t c;
   } umc_row_s;
   logic      aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   umc_addr_t awaddr, araddr;
   umc_word_t wdata, rdata, d;
   umc_strb_t wstrb;
   umc_resp_t bresp, rresp, rs;
   logic      awready, wready, bvalid, arready, rvalid;
   logic      cts_n, cts_change, rx_can_accept, tx_empty, rx_full;
   logic      tx_char_done, rx_parity_err, baud_tick;
   logic      framing_error_flag, overrun_error_flag, noise_error_flag;
   logic      tx_allow, rts_n, tx_dma_req, rx_dma_req, smart_card_mode;
   logic      half_duplex_mode, infrared_mode, infrared_lp_mode;
   logic      nack_pulse, tx_complete, ir_lp_tick, card_clk, irq;
   int        bad_count, checked, n, p;
   // ==========
   // mode rows: written word, readback, mode outputs
   umc_row_s mode_rows [6] = '{
      '{32'h0000_07ff, 32'h0000_07ff, 32'h7f},
      '{32'hffff_f800, 32'h0, 32'h80},
      '{32'h0000_02aa, 32'h0000_02aa, 32'h2e},
      '{32'h0000_0555, 32'h0000_0555, 32'hd0},
      '{32'h0000_0006, 32'h0000_0006, 32'h83},
      '{32'h0, 32'h0, 32'h80}};
   // guard rows: mode word, guard/divider word, ticks before complete
   umc_row_s gt_rows [5] = '{
      '{32'h0, 32'h0500, 32'h0}, '{32'h20, 32'h0, 32'h0},
      '{32'h20, 32'h0101, 32'h1}, '{32'h20, 32'h0305, 32'h3},
      '{32'h20, 32'hff00, 32'hff}};
   // divider rows: mode word, divider, spacing of rising edges
   umc_row_s div_rows [7] = '{
      '{32'h6, 32'h5, 32'h5}, '{32'h6, 32'hff, 32'hff},
      '{32'h6, 32'h0, 32'h0},
      '{32'h2, 32'h1, 32'h0},
      '{32'h20, 32'h23, 32'h6}, '{32'h20, 32'hff, 32'h3e},
      '{32'h20, 32'h20, 32'h0}};
   umc_mode_ctrl umc_mode_ctrl_inst (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .cts_n, .cts_change,
      .rx_can_accept, .tx_empty, .rx_full, .tx_char_done, .rx_parity_err,
      .framing_error_flag, .overrun_error_flag, .noise_error_flag,
      .baud_tick, .tx_allow, .rts_n, .tx_dma_req, .rx_dma_req,
      .smart_card_mode, .half_duplex_mode, .infrared_mode,
      .infrared_lp_mode, .nack_pulse, .tx_complete, .ir_lp_tick,
      .card_clk, .irq
   );
   umc_peer_model umc_peer_model_inst (
      .aclk, .aresetn, .cts_n, .cts_change, .rx_can_accept, .tx_empty,
      .rx_full, .tx_char_done, .rx_parity_err, .framing_error_flag,
      .overrun_error_flag, .noise_error_flag, .baud_tick
   );
   // ==========
   // helpers
   function automatic umc_word_t w(input logic b);
      return {31'h0, b};
   endfunction
   function automatic umc_word_t mode_outs();
      return {24'h0, tx_allow, rts_n, tx_dma_req, rx_dma_req,
              smart_card_mode, half_duplex_mode, infrared_mode,
              infrared_lp_mode};
   endfunction
   task automatic chk(input umc_word_t got, input umc_word_t exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle();
      @(posedge aclk);
      #1;
   endtask
   task automatic results();
      if (bad_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ==========
   // bus cycles; the first edge keeps a released strobe low one cycle
   task automatic axw(input umc_addr_t a, input umc_word_t v,
                      output umc_resp_t r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axr(input umc_addr_t a, output umc_word_t v,
                      output umc_resp_t r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic wr(input umc_addr_t a, input umc_word_t v);
      axw(a, v, rs);
   endtask
   task automatic rd(input umc_addr_t a, input umc_word_t e);
      axr(a, d, rs);
      chk(d, e);
   endtask
   // spacing of rising edges; zero when the output never toggles
   task automatic per(input logic s, output int q);
      logic prev, cur;
      int   k;
      k = -1;
      prev = 1'b1;
      repeat (600)
      begin
         settle();
         cur = s ? card_clk : ir_lp_tick;
         if (k >= 0)
            k++;
         if (cur === 1'b1 && prev === 1'b0)
            if (k > 0)
               break;
            else
               k = 0;
         prev = cur;
      end
      q = (k > 0 && cur === 1'b1 && prev === 1'b0) ? k : 0;
   endtask
   // ==========
   // clock, watchdog, main sequence
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   initial
   begin
      repeat (60000) @(posedge aclk);
      bad_count++;
      results();
   end
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hf;
      bad_count = 0;
      checked = 0;
      repeat (20) @(posedge aclk);
      #1;
      chk(mode_outs(), 32'h80);
      aresetn = 1'b1;
      rd(`UMC_OFS_CTL3, 32'h0);
      rd(`UMC_OFS_GPR, 32'h0);
      rd(`UMC_OFS_IRQ_EN, 32'h0);
      foreach (mode_rows[i])
      begin
         wr(`UMC_OFS_CTL3, mode_rows[i].a);
         rd(`UMC_OFS_CTL3, mode_rows[i].b);
         settle();
         chk(mode_outs(), mode_rows[i].c);
      end
      wr(`UMC_OFS_CTL3, 32'h3c0);
      umc_peer_model_inst.set_lv(4'h6);
      settle();
      chk(mode_outs() >> 4, 32'ha);
      umc_peer_model_inst.set_lv(4'h9);
      settle();
      chk(mode_outs() >> 4, 32'h5);
      wr(`UMC_OFS_GPR, 32'hffff_ffff);
      rd(`UMC_OFS_GPR, 32'h0000_ffff);
      wstrb <= 4'h2;
      wr(`UMC_OFS_GPR, 32'h0000_1200);
      wstrb <= 4'hf;
      rd(`UMC_OFS_GPR, 32'h0000_12ff);
      axw(8'h30, 32'h1, rs);
      chk({30'h0, rs}, 32'h2);
      axr(8'h30, d, rs);
      chk(d, 32'h0);
      chk({30'h0, rs}, 32'h2);
      wr(`UMC_OFS_IRQ_EN, 32'h7);
      wr(`UMC_OFS_CTL3, 32'h400);
      umc_peer_model_inst.pulse(0);
      settle();
      chk(w(irq), 32'h1);
      wr(`UMC_OFS_IRQ_STAT, 32'h0);
      rd(`UMC_OFS_IRQ_STAT, 32'h1);
      wr(`UMC_OFS_IRQ_CLR, 32'h7);
      rd(`UMC_OFS_IRQ_CLR, 32'h0);
      chk(w(irq), 32'h0);
      wr(`UMC_OFS_CTL3, 32'h0);
      umc_peer_model_inst.pulse(0);
      settle();
      chk(w(irq), 32'h0);
      wr(`UMC_OFS_IRQ_CLR, 32'h7);
      wr(`UMC_OFS_IRQ_EN, 32'h0);
      umc_peer_model_inst.pulse(1);
      settle();
      chk(w(irq), 32'h0);
      rd(`UMC_OFS_IRQ_STAT, 32'h4);
      wr(`UMC_OFS_IRQ_EN, 32'h7);
      settle();
      chk(w(irq), 32'h1);
      wr(`UMC_OFS_IRQ_CLR, 32'h7);
      for (int k = 3; k < 6; k++)
      begin
         wr(`UMC_OFS_CTL3, 32'h1);
         umc_peer_model_inst.pulse(k);
         settle();
         chk(w(irq), 32'h0);
         wr(`UMC_OFS_IRQ_CLR, 32'h7);
         wr(`UMC_OFS_CTL3, 32'h41);
         umc_peer_model_inst.pulse(k);
         settle();
         chk(w(irq), 32'h1);
         wr(`UMC_OFS_IRQ_CLR, 32'h7);
      end
      wr(`UMC_OFS_CTL3, 32'h30);
      umc_peer_model_inst.pulse(2);
      #1;
      chk(w(nack_pulse), 32'h1);
      settle();
      chk(w(nack_pulse), 32'h0);
      wr(`UMC_OFS_CTL3, 32'h20);
      umc_peer_model_inst.pulse(2);
      #1;
      chk(w(nack_pulse), 32'h0);
      foreach (gt_rows[i])
      begin
         wr(`UMC_OFS_CTL3, gt_rows[i].a);
         wr(`UMC_OFS_GPR, gt_rows[i].b);
         umc_peer_model_inst.pulse(1);
         n = 0;
         #1;
         repeat (1500)
         begin
            if (tx_complete === 1'b1)
               break;
            n += baud_tick;
            settle();
         end
         chk(umc_word_t'(n), gt_rows[i].c);
      end
      foreach (div_rows[i])
      begin
         wr(`UMC_OFS_CTL3, div_rows[i].a);
         wr(`UMC_OFS_GPR, div_rows[i].b);
         per(div_rows[i].a[5], p);
         chk(umc_word_t'(p), div_rows[i].c);
      end
      // second reset in mid-run, registers set beforehand
      wr(`UMC_OFS_CTL3, 32'h7ff);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`UMC_OFS_CTL3, 32'h0);
      chk(mode_outs(), 32'h80);
      results();
   end
endmodule // testbench
